// >>> logic/iidr_top.sv
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// - an 8-bit read-only revision register returns a fixed per-silicon revision code.
// - identifier bits 31:24 are read-only and bits 22:20 and 12:9 always read zero.
// - bit 23 reads 1 when the checksum capability exists, else 0.
// - writing 0 to the lock bit 19 has no effect on it.
// - writing 1 to the lock bit sets it, if both the fifo and buffer interfaces are implemented, and blocks selector changes.
// - the lock bit clears on every platform init event.
// - selector code 00 picks the fifo interface, 01 the buffer interface, others reserved.
// - a selector write only changes the active interface at the next init event.
// - selector writes are accepted only while the lock reads 0.
// - bits 16:15 always read zero.
// - bit 14 reads 1 when the buffer interface is implemented and selectable.
// - bit 13 reads 1 when the fifo interface is implemented and selectable.
// - bit 8 reads 1 when five localities are supported, else 0.
// - bits 7:4 report 0010 for the buffer interface and 0000 for fifo.
// - bits 3:0 report the active interface kind, 0000 fifo, 0001 buffer.
// - every locality alias of the identifier register returns the same content.
module iidr_top
#(
   parameter logic [7:0] REVISION_CODE = 8'h01, // arbitrary value
   parameter logic CSUM_CAP = 1'b1,
   parameter logic BUF_CAP = 1'b1,
   parameter logic FIFO_CAP = 1'b1,
   parameter logic MULTI_LOC = 1'b1
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic platform_init_event,
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [1:0] active_interface_kind
);
   iidr_bus_if bus();

   logic aw_held_r;
   logic w_held_r;
   logic [15:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic do_write;
   logic wr_id_hit;
   logic wr_init_hit;
   logic wr_known;
   logic [31:0] rdata_nxt;
   logic [1:0] rresp_nxt;
   logic [15:0] rd_loc_off;
   logic rd_in_loc;

   // ----------------------------------------
   // write channel capture
   // ----------------------------------------
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready = !w_held_r && !s_axi_bvalid;
   assign do_write = aw_held_r && w_held_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r <= 1'b0;
         awaddr_r <= 16'h0000;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end
      else if (do_write)
         aw_held_r <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_r <= 1'b0;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end
      else if (do_write)
         w_held_r <= 1'b0;
   end

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   assign wr_id_hit = (awaddr_r[15:12] < 4'(iidr_pkg::NUM_LOC))
                      && ((awaddr_r & iidr_pkg::LOC_OFF_MASK) == iidr_pkg::OFF_IFACE_ID);
   assign wr_init_hit = awaddr_r == iidr_pkg::OFF_INIT_CTRL;
   assign wr_known = wr_id_hit || wr_init_hit || ((awaddr_r[15:12] < 4'(iidr_pkg::NUM_LOC))
                     && ((awaddr_r & iidr_pkg::LOC_OFF_MASK) == iidr_pkg::OFF_REV_ID));

   assign bus.wr_en = do_write && wr_id_hit;
   assign bus.wdata = wdata_r;
   assign bus.wstrb = wstrb_r;
   assign bus.init_evt = platform_init_event
                         || (do_write && wr_init_hit && wstrb_r[0] && wdata_r[0]);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= iidr_pkg::RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_known ? iidr_pkg::RESP_OKAY : iidr_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_loc_off = s_axi_araddr & iidr_pkg::LOC_OFF_MASK;
   assign rd_in_loc = s_axi_araddr[15:12] < 4'(iidr_pkg::NUM_LOC);

   always_comb
   begin
      rdata_nxt = 32'h00000000;
      rresp_nxt = iidr_pkg::RESP_OKAY;
      if (rd_in_loc && rd_loc_off == iidr_pkg::OFF_IFACE_ID)
         rdata_nxt = bus.id_word;
      else if (rd_in_loc && rd_loc_off == iidr_pkg::OFF_REV_ID)
         rdata_nxt = {24'h000000, REVISION_CODE};
      else if (s_axi_araddr != iidr_pkg::OFF_INIT_CTRL)
         rresp_nxt = iidr_pkg::RESP_SLVERR;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= iidr_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdata_nxt;
         s_axi_rresp <= rresp_nxt;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   assign active_interface_kind = bus.active_sel;

   // ----------------------------------------
   // identifier register
   // ----------------------------------------
   iidr_ident
   #(
      .CSUM_CAP(CSUM_CAP),
      .BUF_CAP(BUF_CAP),
      .FIFO_CAP(FIFO_CAP),
      .MULTI_LOC(MULTI_LOC)
   )
   u_ident
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .bus(bus)
   );

   chk_rev_read:
      assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && rd_in_loc && rd_loc_off == iidr_pkg::OFF_REV_ID
      |=> s_axi_rvalid && s_axi_rdata == {24'h000000, REVISION_CODE})
      else $error("revision read wrong");
   chk_reserved_zero:
      assert property (@(posedge aclk) disable iff (!aresetn)
      bus.id_word[31:24] == 8'h00 && bus.id_word[22:20] == 3'h0
      && bus.id_word[12:9] == 4'h0 && bus.id_word[16:15] == 2'h0)
      else $error("reserved bits nonzero");
   chk_caps_fixed:
      assert property (@(posedge aclk) disable iff (!aresetn)
      bus.id_word[23] == CSUM_CAP && bus.id_word[14] == BUF_CAP
      && bus.id_word[13] == FIFO_CAP && bus.id_word[8] == MULTI_LOC)
      else $error("capability bits wrong");
   chk_write_resp:
      assert property (@(posedge aclk) disable iff (!aresetn)
      do_write |=> s_axi_bvalid)
      else $error("write not answered");
   chk_read_resp:
      assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   cov_id_read: cover property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && rd_loc_off == iidr_pkg::OFF_IFACE_ID);
   cov_id_write: cover property (@(posedge aclk) disable iff (!aresetn) bus.wr_en);
endmodule

// >>> include/iidr_pkg.sv
package iidr_pkg;
   // register byte offsets, one locality window (aliased per locality), plus the init control register at 0x5000 outside the windows
   localparam logic [15:0] OFF_IFACE_ID = 16'h0030;
   localparam logic [15:0] OFF_REV_ID = 16'h0F04;
   localparam logic [15:0] LOC_STRIDE = 16'h1000;
   localparam logic [15:0] LOC_OFF_MASK = 16'h0FFF;
   localparam logic [2:0] NUM_LOC = 3'h5;
   localparam logic [15:0] OFF_INIT_CTRL = 16'h5000;
   // interface identifier field positions
   localparam int BIT_CSUM = 23;
   localparam int BIT_LOCK = 19;
   localparam int SEL_LSB = 17;
   localparam int BIT_BUF_CAP = 14;
   localparam int BIT_FIFO_CAP = 13;
   localparam int BIT_MULTI_LOC = 8;
   localparam int REV_LSB = 4;
   localparam int KIND_LSB = 0;
   // encodings
   localparam logic [1:0] SEL_FIFO = 2'h0;
   localparam logic [1:0] SEL_BUF = 2'h1;
   localparam logic [3:0] KIND_FIFO = 4'h0;
   localparam logic [3:0] KIND_BUF = 4'h1;
   localparam logic [3:0] KIND_OLD_FIFO = 4'hF;
   localparam logic [3:0] IREV_FIFO = 4'h0;
   localparam logic [3:0] IREV_BUF = 4'h2;
   // reset values and bus response codes
   localparam logic [1:0] SEL_RESET = 2'h0;
   localparam logic LOCK_RESET = 1'b0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> include/iidr_bus_if.sv
`timescale 1ns/1ps
interface iidr_bus_if;
   logic wr_en;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic init_evt;
   logic [1:0] active_sel;
   logic lock;
   logic [31:0] id_word;
   modport ctrl
   (
      output wr_en,
      output wdata,
      output wstrb,
      output init_evt,
      input active_sel,
      input lock,
      input id_word
   );
   modport regs
   (
      input wr_en,
      input wdata,
      input wstrb,
      input init_evt,
      output active_sel,
      output lock,
      output id_word
   );
endinterface

// >>> logic/iidr_ident.sv
`timescale 1ns/1ps
module iidr_ident
#(
   parameter logic CSUM_CAP = 1'b1,
   parameter logic BUF_CAP = 1'b1,
   parameter logic FIFO_CAP = 1'b1,
   parameter logic MULTI_LOC = 1'b1
)
(
   input wire logic aclk,
   input wire logic aresetn,
   iidr_bus_if.regs bus
);
   logic lock_r;
   logic [1:0] pend_sel_r;
   logic [1:0] active_sel_r;
   logic sel_ok;
   logic [1:0] wr_sel;

   // ----------------------------------------
   // selector and lock
   // ----------------------------------------
   assign wr_sel = bus.wdata[iidr_pkg::SEL_LSB +: 2];
   assign sel_ok = FIFO_CAP && BUF_CAP && !lock_r && bus.wstrb[2] && bus.wr_en
                   && (wr_sel == iidr_pkg::SEL_FIFO || wr_sel == iidr_pkg::SEL_BUF);

   always_ff @(posedge aclk)
   begin
      if (!aresetn || bus.init_evt)
         lock_r <= iidr_pkg::LOCK_RESET;
      else if (bus.wr_en && bus.wstrb[2] && bus.wdata[iidr_pkg::BIT_LOCK] && FIFO_CAP && BUF_CAP)
         lock_r <= 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pend_sel_r <= iidr_pkg::SEL_RESET;
      else if (sel_ok)
         pend_sel_r <= wr_sel;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         active_sel_r <= BUF_CAP && !FIFO_CAP ? iidr_pkg::SEL_BUF : iidr_pkg::SEL_FIFO;
      else if (bus.init_evt)
         active_sel_r <= pend_sel_r;
   end

   // ----------------------------------------
   // read word
   // ----------------------------------------
   always_comb
   begin
      bus.id_word = 32'h00000000;
      bus.id_word[iidr_pkg::BIT_CSUM] = CSUM_CAP;
      bus.id_word[iidr_pkg::BIT_LOCK] = lock_r;
      bus.id_word[iidr_pkg::SEL_LSB +: 2] = pend_sel_r;
      bus.id_word[iidr_pkg::BIT_BUF_CAP] = BUF_CAP;
      bus.id_word[iidr_pkg::BIT_FIFO_CAP] = FIFO_CAP;
      bus.id_word[iidr_pkg::BIT_MULTI_LOC] = MULTI_LOC;
      bus.id_word[iidr_pkg::REV_LSB +: 4] = (active_sel_r == iidr_pkg::SEL_BUF) ?
         iidr_pkg::IREV_BUF : iidr_pkg::IREV_FIFO;
      bus.id_word[iidr_pkg::KIND_LSB +: 4] = (active_sel_r == iidr_pkg::SEL_BUF) ?
         iidr_pkg::KIND_BUF : iidr_pkg::KIND_FIFO;
   end
   assign bus.active_sel = active_sel_r;
   assign bus.lock = lock_r;

   chk_lock_holds_sel:
      assert property (@(posedge aclk) disable iff (!aresetn)
      lock_r && !bus.init_evt |=> $stable(pend_sel_r))
      else $error("selector changed while locked");
   chk_active_waits_init:
      assert property (@(posedge aclk) disable iff (!aresetn)
      !bus.init_evt |=> $stable(active_sel_r))
      else $error("active interface changed without init");
   chk_init_clears_lock:
      assert property (@(posedge aclk) disable iff (!aresetn)
      bus.init_evt |=> !lock_r)
      else $error("lock not cleared by init");
   chk_lock_sticky:
      assert property (@(posedge aclk) disable iff (!aresetn)
      lock_r && !bus.init_evt |=> lock_r)
      else $error("lock dropped without init");
   chk_kind_matches:
      assert property (@(posedge aclk) disable iff (!aresetn)
      bus.id_word[3:0] == ((active_sel_r == iidr_pkg::SEL_BUF) ? 4'h1 : 4'h0)
      && bus.id_word[7:4] == ((active_sel_r == iidr_pkg::SEL_BUF) ? 4'h2 : 4'h0))
      else $error("type or version field wrong");
   cov_lock_set: cover property (@(posedge aclk) disable iff (!aresetn) $rose(lock_r));
   cov_switch: cover property (@(posedge aclk) disable iff (!aresetn)
      bus.init_evt ##1 $changed(active_sel_r));
endmodule

// >>> sim/iidr_bench.sv
`timescale 1ns/1ps
module iidr_bench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic platform_init_event = 1'b0;
   logic [15:0] awaddr = 16'h0000;
   logic [15:0] araddr = 16'h0000;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, kind;
   logic [31:0] rdata;
   int failures = 0;
   int checked = 0;

   always #4 aclk = ~aclk;

   iidr_top dut_u
   (
      .aclk(aclk), .aresetn(aresetn), .platform_init_event(platform_init_event),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .active_interface_kind(kind)
   );

   // ---------------------------------------------------------------
   // bus and check helpers
   // ---------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_hs, w_hs, b_hs;
      logic [1:0] r;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         #1;
         aw_hs = awvalid && awready;
         w_hs = wvalid && wready;
         b_hs = bvalid;
         r = bresp;
         @(posedge aclk);
         if (aw_hs) awvalid <= 1'b0;
         if (w_hs) wvalid <= 1'b0;
      end
      while (b_hs !== 1'b1);
      bready <= 1'b0;
      check("bresp", {30'h0, r}, {30'h0, er});
   endtask

   task automatic rchk(input string name, input logic [15:0] a, input logic [31:0] e,
                       input logic [1:0] er);
      logic ar_hs, r_hs;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         #1;
         ar_hs = arvalid && arready;
         r_hs = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ar_hs) arvalid <= 1'b0;
      end
      while (r_hs !== 1'b1);
      rready <= 1'b0;
      check("rresp", {30'h0, r}, {30'h0, er});
      if (er === iidr_pkg::RESP_OKAY) check(name, d, e);
   endtask

   task automatic pulse_init;
      @(posedge aclk);
      platform_init_event <= 1'b1;
      @(posedge aclk);
      platform_init_event <= 1'b0;
   endtask

   // expected identifier word, all capabilities present
   function automatic logic [31:0] idw(input logic lk, input logic [1:0] sel, input logic bf);
      return {8'h00, 1'b1, 3'h0, lk, sel, 2'h0, 2'h3, 4'h0, 1'b1,
              bf ? 4'h2 : 4'h0, bf ? 4'h1 : 4'h0};
   endfunction

   task automatic end_sim;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic test_reset;
      rchk("revision_id", 16'h0F04, 32'h00000001, iidr_pkg::RESP_OKAY);
      rchk("id reset", 16'h0030, idw(0, 2'h0, 0), iidr_pkg::RESP_OKAY);
      wr(16'h0F04, 32'hFFFFFFFF, iidr_pkg::RESP_OKAY);
      rchk("revision_id ro", 16'h0F04, 32'h00000001, iidr_pkg::RESP_OKAY);
      $display("test reset done");
   endtask

   task automatic test_select;
      wr(16'h0030, 32'h00020000, iidr_pkg::RESP_OKAY);
      rchk("id pending", 16'h0030, idw(0, 2'h1, 0), iidr_pkg::RESP_OKAY);
      check("kind before init", {30'h0, kind}, 32'h0);
      pulse_init();
      rchk("id buffer", 16'h0030, idw(0, 2'h1, 1), iidr_pkg::RESP_OKAY);
      check("kind after init", {30'h0, kind}, 32'h1);
      $display("test select done");
   endtask

   task automatic test_lock;
      wr(16'h0030, 32'hFFFFFFFF, iidr_pkg::RESP_OKAY);
      rchk("id locked", 16'h0030, idw(1, 2'h1, 1), iidr_pkg::RESP_OKAY);
      wr(16'h0030, 32'h00000000, iidr_pkg::RESP_OKAY);
      rchk("id lock held", 16'h0030, idw(1, 2'h1, 1), iidr_pkg::RESP_OKAY);
      for (int l = 0; l < 5; l++)
      begin
         rchk("id alias", 16'(l * 16'h1000 + 16'h0030), idw(1, 2'h1, 1),
              iidr_pkg::RESP_OKAY);
         rchk("rev alias", 16'(l * 16'h1000 + 16'h0F04), 32'h00000001,
              iidr_pkg::RESP_OKAY);
      end
      pulse_init();
      rchk("id pin unlock", 16'h0030, idw(0, 2'h1, 1), iidr_pkg::RESP_OKAY);
      wr(16'h0030, 32'h000A0000, iidr_pkg::RESP_OKAY);
      rchk("id relocked", 16'h0030, idw(1, 2'h1, 1), iidr_pkg::RESP_OKAY);
      wr(16'h5000, 32'h00000001, iidr_pkg::RESP_OKAY);
      rchk("id unlocked", 16'h0030, idw(0, 2'h1, 1), iidr_pkg::RESP_OKAY);
      wr(16'h0030, 32'h00000000, iidr_pkg::RESP_OKAY);
      rchk("id sel fifo", 16'h0030, idw(0, 2'h0, 1), iidr_pkg::RESP_OKAY);
      pulse_init();
      rchk("id fifo", 16'h0030, idw(0, 2'h0, 0), iidr_pkg::RESP_OKAY);
      check("kind fifo", {30'h0, kind}, 32'h0);
      $display("test lock done");
   endtask

   task automatic test_unmapped;
      rchk("unmapped", 16'h0100, 32'h0, iidr_pkg::RESP_SLVERR);
      wr(16'h0100, 32'h00020000, iidr_pkg::RESP_SLVERR);
      rchk("id intact", 16'h0030, idw(0, 2'h0, 0), iidr_pkg::RESP_OKAY);
      $display("test unmapped done");
   endtask

   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      test_reset();
      test_select();
      test_lock();
      test_unmapped();
      end_sim();
   end

   initial
   begin
      repeat (5000) @(posedge aclk);
      failures++;
      end_sim();
   end
endmodule
